// *** pep_pkg.sv ***
// Purpose: Shared constants for the parallel byte-wide memory host.
// Assumes: 40 MHz system clock; all times in ns, converted to cycles.
// Notes:   Least times and the access time round up to whole cycles, the byte load window rounds down.
package pep_pkg;

  // Bus geometry
  localparam int ADDR_W     = 15;
  localparam int DATA_W     = 8;
  localparam int PAGE_LSB   = 6;
  localparam int PAGE_BYTES = 64;
  localparam int TOG_BIT    = 6;
  localparam int SYNC_LAT   = 2;

  // Times as printed or chosen, in ns
  localparam int CLK_NS   = 25;
  localparam int T_SU_NS  = 50;
  localparam int T_WP_NS  = 100;
  localparam int T_HD_NS  = 50;
  localparam int T_ACC_NS = 200;
  localparam int T_BLC_NS = 100000;
  localparam int T_GLITCH_NS = 20;

  // Derived cycle counts
  localparam int SU_CYC  = (T_SU_NS + CLK_NS - 1) / CLK_NS;
  localparam int WP_CYC  = (T_WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int HD_CYC  = (T_HD_NS + CLK_NS - 1) / CLK_NS;
  localparam int ACC_CYC = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
  localparam int BLC_CYC = T_BLC_NS / CLK_NS;
  localparam int GUARD_CYC = 8;
  localparam int WR_END  = SU_CYC + WP_CYC + HD_CYC;
  localparam int RD_END  = ACC_CYC + SYNC_LAT + 1;
  localparam int OPEN_LIM = BLC_CYC - GUARD_CYC - SU_CYC - 1;
  localparam int POLL_AT  = BLC_CYC + GUARD_CYC;

  // Command sequence table slots
  localparam int       SEQ_N         = 9;
  localparam logic [3:0] SEQ_PROT_FIRST = 4'h0;
  localparam logic [3:0] SEQ_PROT_LAST  = 4'h2;
  localparam logic [3:0] SEQ_RST_FIRST  = 4'h3;
  localparam logic [3:0] SEQ_RST_LAST   = 4'h8;

  typedef enum logic [1:0] {OP_READ, OP_WRITE, OP_UNLOCK} pep_op_t;

endpackage

// *** pep_sync.sv ***
// Purpose: Two-stage synchroniser for the inbound data pins.
// Assumes: Input changes asynchronously to clk_i.
// Notes:   First stage feeds only the second stage.
`timescale 1ns/1ps
`default_nettype none
module pep_sync #(
  parameter int W = 8
) (
  input  wire logic         clk_i,   // System clock
  input  wire logic         rst_i,   // Async reset, high
  input  wire logic [W-1:0] d_i,     // Asynchronous input
  output var  logic [W-1:0] q_o      // Synchronised output
);
  logic [W-1:0] meta;

  // Two flops, reset to zero
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta <= '0;
      q_o  <= '0;
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end
endmodule // pep_sync
`default_nettype wire

// *** pep_host.sv ***
// Purpose: Host controller driving a byte-wide self-timed memory by pins.
// Assumes: 40 MHz clk_i; memory data lines return via mem_data_i.
// Notes:   Command port below; pins are registered, one cycle behind state.
`timescale 1ns/1ps
`default_nettype none
module pep_host
  import pep_pkg::*;
#(
  // Arbitrary neutral command sequence; slots 0-2 protect, 3-8 reset
  parameter logic [14:0] SEQ_ADDR [SEQ_N] = '{15'h0ACE, 15'h0531, 15'h0ACE,
    15'h0ACE, 15'h0531, 15'h0ACE, 15'h0ACE, 15'h0531, 15'h0ACE},
  parameter logic [7:0]  SEQ_DATA [SEQ_N] = '{8'h5A, 8'hA5, 8'h3C,
    8'h5A, 8'hA5, 8'hC3, 8'h5A, 8'hA5, 8'h69}
) (
  input  wire logic                  clk_i,           // 40 MHz clock
  input  wire logic                  rst_i,           // Async reset, high
  input  wire logic                  cmd_valid_i,     // Command offered
  input  wire pep_pkg::pep_op_t      cmd_op_i,        // Read/write/unlock
  input  wire logic [pep_pkg::ADDR_W-1:0] cmd_addr_i, // Byte address
  input  wire logic [pep_pkg::DATA_W-1:0] cmd_data_i, // Write data
  input  wire logic                  cmd_prot_i,      // Prefix protect seq
  input  wire logic                  cmd_last_i,      // Close page load
  output var  logic                  ready_o,         // Ready for a command
  output var  logic [pep_pkg::DATA_W-1:0] rd_data_o,  // Read result
  output var  logic                  rd_valid_o,      // Read result pulse
  output var  logic                  done_o,          // Programming over
  output var  logic                  busy_o,          // Not idle
  output var  logic [pep_pkg::ADDR_W-1:0] mem_addr_o, // byte_address pins
  output var  logic                  mem_ce_n_o,      // device_select_n
  output var  logic                  mem_oe_n_o,      // output_gate_n
  output var  logic                  mem_we_n_o,      // write_strobe_n
  output var  logic [pep_pkg::DATA_W-1:0] mem_data_o, // data_bus out
  input  wire logic [pep_pkg::DATA_W-1:0] mem_data_i, // data_bus in
  output var  logic                  mem_data_oe_n_o  // Low: host drives
);
  import pep_pkg::*;

  // Refuse timings the pin engine cannot honour
  if (WP_CYC * CLK_NS <= T_GLITCH_NS) begin : g_chk_wp
    $error("write strobe width too short");
  end
  if (OPEN_LIM < 1 || WR_END > 255 || RD_END > 255) begin : g_chk_cnt
    $error("cycle counts out of range");
  end

  typedef enum logic [2:0] {
    S_IDLE, S_SEQ, S_DATA, S_OPEN, S_READ, S_POLLA, S_POLLB
  } pep_state_t;

  pep_state_t         state, next_state;
  logic [3:0]         idx, next_idx, last_idx, next_last_idx;
  logic               then_data, next_then_data;
  logic               more_ok, next_more_ok;
  logic [6:0]         pcnt, next_pcnt;
  logic [ADDR_W-1:0]  addr_r, next_addr_r;
  logic [DATA_W-1:0]  data_r, next_data_r;
  logic [ADDR_W-PAGE_LSB-1:0] page_r, next_page_r;
  logic               tog_prev, next_tog_prev;
  logic [7:0]         cnt;
  logic [11:0]        tmr;
  logic [DATA_W-1:0]  data_sync;
  logic               acc_wr, acc_rd, acc_done, take, fits;
  logic               next_we_n;

  pep_sync #(.W(DATA_W)) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (mem_data_i),
    .q_o   (data_sync)
  );

  // Access engine decode
  assign acc_wr   = (state == S_SEQ) || (state == S_DATA);
  assign acc_rd   = (state == S_READ) || (state == S_POLLA) ||
                    (state == S_POLLB);
  assign acc_done = acc_wr ? (cnt == 8'(WR_END - 1)) :
                    acc_rd ? (cnt == 8'(RD_END - 1)) : 1'b0;
  // A further byte must stay in the same page and plain
  assign fits = (cmd_op_i == OP_WRITE) && !cmd_prot_i &&
                (cmd_addr_i[ADDR_W-1:PAGE_LSB] == page_r);
  assign take = cmd_valid_i && ready_o &&
                ((state == S_IDLE) || ((state == S_OPEN) && fits));

  // Next-state logic for the command sequencer
  always_comb begin
    next_state     = state;
    next_idx       = idx;
    next_last_idx  = last_idx;
    next_then_data = then_data;
    next_more_ok   = more_ok;
    next_pcnt      = pcnt;
    next_addr_r    = addr_r;
    next_data_r    = data_r;
    next_page_r    = page_r;
    next_tog_prev  = tog_prev;
    unique case (state)
      S_IDLE: begin
        if (take) begin
          next_addr_r  = cmd_addr_i;
          next_data_r  = cmd_data_i;
          next_more_ok = !cmd_last_i;
          next_pcnt    = 7'h00;
          unique case (cmd_op_i)
            OP_READ:   next_state = S_READ;
            OP_WRITE: begin
              if (cmd_prot_i) begin
                next_idx       = SEQ_PROT_FIRST;
                next_last_idx  = SEQ_PROT_LAST;
                next_then_data = 1'b1;
                next_state     = S_SEQ;
              end else begin
                next_state = S_DATA;
              end
            end
            OP_UNLOCK: begin
              next_idx       = SEQ_RST_FIRST;
              next_last_idx  = SEQ_RST_LAST;
              next_then_data = 1'b0;
              next_state     = S_SEQ;
            end
            default: next_state = S_IDLE;
          endcase
        end
      end
      S_SEQ: begin
        // Sequence runs back to back, no other access between
        if (acc_done) begin
          if (idx == last_idx) begin
            next_state   = then_data ? S_DATA : S_OPEN;
            next_more_ok = then_data ? more_ok : 1'b0;
          end else begin
            next_idx = idx + 4'h1;
          end
        end
      end
      S_DATA: begin
        if (acc_done) begin
          next_pcnt   = pcnt + 7'h01;
          next_page_r = addr_r[ADDR_W-1:PAGE_LSB];
          next_state  = S_OPEN;
        end
      end
      S_OPEN: begin
        if (take) begin
          next_addr_r  = cmd_addr_i;
          next_data_r  = cmd_data_i;
          next_more_ok = !cmd_last_i;
          next_state   = S_DATA;
        end else if (tmr >= 12'(POLL_AT)) begin
          next_state = S_POLLA;
        end
      end
      S_READ: begin
        if (acc_done) next_state = S_IDLE;
      end
      S_POLLA: begin
        if (acc_done) begin
          next_tog_prev = data_sync[TOG_BIT];
          next_state    = S_POLLB;
        end
      end
      S_POLLB: begin
        // Stable bit 6 on two reads in a row means programming is over
        if (acc_done) begin
          next_tog_prev = data_sync[TOG_BIT];
          if (data_sync[TOG_BIT] == tog_prev) next_state = S_IDLE;
        end
      end
      default: next_state = S_IDLE;
    endcase
  end

  // Sequencer registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state     <= S_IDLE;
      idx       <= 4'h0;
      last_idx  <= 4'h0;
      then_data <= 1'b0;
      more_ok   <= 1'b0;
      pcnt      <= 7'h00;
      addr_r    <= '0;
      data_r    <= '0;
      page_r    <= '0;
      tog_prev  <= 1'b0;
    end else begin
      state     <= next_state;
      idx       <= next_idx;
      last_idx  <= next_last_idx;
      then_data <= next_then_data;
      more_ok   <= next_more_ok;
      pcnt      <= next_pcnt;
      addr_r    <= next_addr_r;
      data_r    <= next_data_r;
      page_r    <= next_page_r;
      tog_prev  <= next_tog_prev;
    end
  end

  // Phase counter; restarting at zero forces a select gap per access
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) cnt <= 8'h00;
    else if (acc_done || !(acc_wr || acc_rd)) cnt <= 8'h00;
    else cnt <= cnt + 8'h01;
  end

  assign next_we_n = !(acc_wr && cnt >= 8'(SU_CYC) &&
                       cnt < 8'(SU_CYC + WP_CYC));

  // Time since last strobe fall; saturates
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) tmr <= 12'hFFF;
    else if (mem_we_n_o && !next_we_n) tmr <= 12'h000;
    else if (tmr != 12'hFFF) tmr <= tmr + 12'h001;
  end

  // Memory pins; gate stays high for whole write access
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      mem_ce_n_o      <= 1'b1;
      mem_oe_n_o      <= 1'b1;
      mem_we_n_o      <= 1'b1;
      mem_addr_o      <= '0;
      mem_data_o      <= '0;
      mem_data_oe_n_o <= 1'b1;
    end else begin
      mem_ce_n_o      <= !((acc_wr || acc_rd) && !acc_done);
      mem_oe_n_o      <= !(acc_rd && !acc_done);
      mem_we_n_o      <= next_we_n;
      mem_addr_o      <= (state == S_SEQ) ? SEQ_ADDR[idx] : addr_r;
      mem_data_o      <= (state == S_SEQ) ? SEQ_DATA[idx] : data_r;
      mem_data_oe_n_o <= !(acc_wr && !acc_done);
    end
  end

  // User-side status
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ready_o    <= 1'b0;
      busy_o     <= 1'b0;
      done_o     <= 1'b0;
      rd_valid_o <= 1'b0;
      rd_data_o  <= '0;
    end else begin
      // Busy programming refuses new commands
      ready_o    <= (next_state == S_IDLE) ||
                    (next_state == S_OPEN && next_more_ok &&
                     next_pcnt < 7'(PAGE_BYTES) &&
                     tmr < 12'(OPEN_LIM - 1));
      busy_o     <= next_state != S_IDLE;
      done_o     <= (state == S_POLLB) && (next_state == S_IDLE);
      rd_valid_o <= (state == S_READ) && acc_done;
      if ((state == S_READ) && acc_done) rd_data_o <= data_sync;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_read_select: assert property (!mem_oe_n_o |-> !mem_ce_n_o)
    else $error("read gate low without select");
  a_write_gate: assert property (!mem_we_n_o |->
      !mem_ce_n_o && mem_oe_n_o)
    else $error("strobe low with gate low or no select");
  a_bus_float: assert property (!mem_data_oe_n_o |-> mem_oe_n_o)
    else $error("host drives bus during read");
  a_strobe_width: assert property ($fell(mem_we_n_o) |->
      !mem_we_n_o [*4] ##1 mem_we_n_o)
    else $error("strobe width wrong");
  a_data_hold: assert property ($rose(mem_we_n_o) |->
      $stable(mem_data_o) && !mem_data_oe_n_o && !mem_ce_n_o)
    else $error("data not held at strobe rise");
  a_page_same: assert property ($fell(mem_we_n_o) && state == S_DATA &&
      pcnt != 7'h00 |-> mem_addr_o[ADDR_W-1:PAGE_LSB] == page_r)
    else $error("page field changed in load");
  a_load_gap: assert property ($fell(mem_we_n_o) && state == S_DATA &&
      pcnt != 7'h00 |-> $past(tmr) < 12'(BLC_CYC))
    else $error("byte load gap too long");
  a_poll_wait: assert property (state == S_POLLA &&
      $past(state) == S_OPEN |-> $past(tmr) >= 12'(BLC_CYC))
    else $error("poll began before load closed");
  a_done_toggle: assert property (done_o |->
      $past(state) == S_POLLB &&
      $past(data_sync[TOG_BIT]) == $past(tog_prev))
    else $error("done without toggle poll");
  a_page_limit: assert property (state == S_DATA |->
      pcnt < 7'(PAGE_BYTES))
    else $error("page load over limit");

endmodule // pep_host
`default_nettype wire

// *** pep_mem_model.sv ***
// Purpose: Behavioural byte-wide self-timed memory facing the host.
// Assumes: Times in ns; programming time shortened by a parameter.
// Notes:   Undriven data bus shows the inverse of its last level.
`timescale 1ns/1ps
`default_nettype none
module pep_mem_model #(
  parameter logic [14:0] SEQ_ADDR [9] = '{default: 15'h0000},
  parameter logic [7:0]  SEQ_DATA [9] = '{default: 8'h00},
  parameter int          PROG_NS      = 20000
) (
  input  wire logic [14:0] addr_i,      // byte_address
  input  wire logic        ce_n_i,      // device_select_n
  input  wire logic        oe_n_i,      // output_gate_n
  input  wire logic        we_n_i,      // write_strobe_n
  input  wire logic [7:0]  host_d_i,    // Host data
  input  wire logic        host_oe_n_i, // Low: host drives
  output var  logic [7:0]  bus_o        // data_bus level
);
  logic [7:0]  mem [32768];
  logic [7:0]  pg [64];
  logic [63:0] pmask;
  logic [22:0] hist [6];
  logic [14:0] wa, pa;
  logic [7:0]  held, rd_val, lw_d;
  logic        prot, win, busy, tog, ok, rst_pend, open;
  realtime     t_st, t_last;
  wire wsel  = !ce_n_i && !we_n_i && oe_n_i;
  wire rd_on = !ce_n_i && !oe_n_i;

  // Delivered blank and unprotected
  initial begin
    foreach (mem[i]) mem[i] = 8'hFF;
    foreach (hist[i]) hist[i] = '0;
    prot = 0;
    {win, busy, tog, ok, rst_pend, open, held, lw_d} = '0;
    {pmask, wa, pa} = '0;
    t_st = 0.0;
    t_last = 0.0;
  end

  // Command bytes are loaded like data, then dropped once matched
  task automatic take(input logic [14:0] a, input logic [7:0] d);
    bit pm, rm;
    if (busy) return;
    for (int k = 5; k > 0; k--) hist[k] = hist[k-1];
    hist[0] = {a, d};
    pm = 1;
    rm = 1;
    for (int k = 0; k < 6; k++) begin
      if (k < 3 && hist[k] != {SEQ_ADDR[2-k], SEQ_DATA[2-k]}) pm = 0;
      if (hist[k] != {SEQ_ADDR[8-k], SEQ_DATA[8-k]}) rm = 0;
    end
    if (!open) begin
      ok = !prot || win;
      pmask = '0;
    end
    t_last = t_st;
    if (pm) begin
      {prot, win, ok, pmask} = {3'b111, 64'h0};
    end else if (rm) begin
      {rst_pend, pmask} = {1'b1, 64'h0};
    end else begin
      if (pmask == '0) pa = a;
      pg[a[5:0]] = d;
      pmask[a[5:0]] = 1'b1;
      lw_d = d;
    end
    open = 1;
  endtask

  // Address on the later fall, data on the earlier rise
  always @(posedge wsel) begin
    wa = addr_i;
    t_st = $realtime;
  end
  always @(negedge wsel) begin
    if ($realtime - t_st >= 20.0) take(wa, bus_o);
  end

  // Load closes after 100 us without a strobe fall, then self-timed
  always @(posedge open) begin
    while ($realtime - t_last < 100000.0)
      #(100000.0 - ($realtime - t_last));
    open = 0;
    if (rst_pend || (ok && pmask != '0)) begin
      busy = 1;
      #(PROG_NS);
      for (int i = 0; i < 64; i++)
        if (ok && pmask[i]) mem[{pa[14:6], 6'(i)}] = pg[i];
      if (rst_pend) prot = 0;
      {rst_pend, busy} = 2'b00;
    end
    win = 0;
  end

  // Toggle once per read while busy; value follows the address, no edge race
  always @(posedge rd_on) begin
    if (busy) tog = ~tog;
  end

  // Status bits while programming, true data after
  always @* begin
    if (busy) rd_val = {~lw_d[7], tog, mem[addr_i][5:0]};
    else rd_val = mem[addr_i];
  end

  // Bus level: host, then device, else the inverse of the last driven level
  always @* begin
    if (!host_oe_n_i) bus_o = host_d_i;
    else if (rd_on) bus_o = rd_val;
    else bus_o = ~held;
  end
  always @(bus_o) if (!host_oe_n_i || rd_on) held = bus_o;
endmodule // pep_mem_model
`default_nettype wire

// *** pep_host_tb.sv ***
// Purpose: Self-checking bench for the byte-wide memory host.
// Assumes: Model programming time well under the 100 us window.
// Notes:   Inputs change at the falling clock edge only.
`timescale 1ns/1ps
`default_nettype none
module pep_host_tb;
  import pep_pkg::*;
  localparam logic [14:0] SA [SEQ_N] = '{15'h0ACE, 15'h0531, 15'h0ACE,
    15'h0ACE, 15'h0531, 15'h0ACE, 15'h0ACE, 15'h0531, 15'h0ACE};
  localparam logic [7:0] SD [SEQ_N] = '{8'h5A, 8'hA5, 8'h3C,
    8'h5A, 8'hA5, 8'hC3, 8'h5A, 8'hA5, 8'h69};
  localparam int LIMIT = 60000;
  logic        clk, rst, valid, prot, last, ready, rvld, done, busy;
  logic        ce_n, oe_n, we_n, doe_n;
  pep_op_t     op;
  logic [14:0] addr, maddr;
  logic [7:0]  wd, rd, mdo, mdi;
  int          err_count, n_compared, cyc;

  pep_host #(.SEQ_ADDR(SA), .SEQ_DATA(SD)) i_dut (
    .clk_i(clk), .rst_i(rst), .cmd_valid_i(valid), .cmd_op_i(op),
    .cmd_addr_i(addr), .cmd_data_i(wd), .cmd_prot_i(prot),
    .cmd_last_i(last), .ready_o(ready), .rd_data_o(rd),
    .rd_valid_o(rvld), .done_o(done), .busy_o(busy),
    .mem_addr_o(maddr), .mem_ce_n_o(ce_n), .mem_oe_n_o(oe_n),
    .mem_we_n_o(we_n), .mem_data_o(mdo), .mem_data_i(mdi),
    .mem_data_oe_n_o(doe_n));
  pep_mem_model #(.SEQ_ADDR(SA), .SEQ_DATA(SD)) i_mem (
    .addr_i(maddr), .ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n),
    .host_d_i(mdo), .host_oe_n_i(doe_n), .bus_o(mdi));

  // Clock
  initial clk = 1'b0;
  always #12.5 clk = ~clk;

  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk_data(input logic [7:0] got, exp, input string m);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, exp, input string m);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t %s got %b", $time, m, got);
    end
  endtask

  // Held until ready seen; ready only moves on rising edges
  task automatic send(input pep_op_t o, input logic [14:0] a,
                      input logic [7:0] d, input logic p, l);
    @(negedge clk);
    {valid, op, addr, wd, prot, last} = {1'b1, o, a, d, p, l};
    for (int n = 0; n < 9000 && ready !== 1'b1; n++) @(negedge clk);
    @(negedge clk);
    valid = 1'b0;
  endtask

  task automatic wait_done();
    chk_bit(busy, 1'b1, "not busy");
    for (int n = 0; n < 9000 && done !== 1'b1; n++) @(negedge clk);
    chk_bit(done, 1'b1, "no done");
    chk_bit(busy, 1'b0, "still busy");
  endtask

  task automatic rd_chk(input logic [14:0] a, input logic [7:0] e);
    send(OP_READ, a, 8'h00, 1'b0, 1'b0);
    for (int n = 0; n < 40 && rvld !== 1'b1; n++) @(negedge clk);
    chk_bit(rvld, 1'b1, "no read data");
    chk_data(rd, e, "read");
  endtask

  // Single byte, bit 7 low so polling sees the complement
  task automatic t_byte();
    rd_chk(15'h7FFF, 8'hFF);
    send(OP_WRITE, 15'h1234, 8'h4B, 1'b0, 1'b1);
    wait_done();
    rd_chk(15'h1234, 8'h4B);
  endtask

  // Full 64-byte page in one load
  task automatic t_page();
    for (int i = 0; i < 64; i++)
      send(OP_WRITE, {9'h0A5, 6'(i)}, 8'hC0 ^ 8'(i), 1'b0, i == 63);
    wait_done();
    rd_chk(15'h2940, 8'hC0);
    rd_chk(15'h2955, 8'hD5);
  endtask

  // Protect, reject a bare write, clear, then write freely
  task automatic t_prot();
    send(OP_WRITE, 15'h2000, 8'h81, 1'b1, 1'b1);
    wait_done();
    rd_chk(15'h2000, 8'h81);
    send(OP_WRITE, 15'h2000, 8'h7E, 1'b0, 1'b1);
    wait_done();
    rd_chk(15'h2000, 8'h81);
    send(OP_UNLOCK, 15'h2000, 8'h00, 1'b0, 1'b0);
    wait_done();
    send(OP_WRITE, 15'h2000, 8'h7E, 1'b0, 1'b1);
    wait_done();
    rd_chk(15'h2000, 8'h7E);
  endtask

  // Strobe and host drive only with the gate high
  always @(negedge clk)
    if (!rst && (!we_n || !doe_n)) chk_bit(oe_n, 1'b1, "gate low");

  // Poll of the single byte while programming shows inverted bit 7
  always @(negedge clk)
    if (!ce_n && !oe_n && i_mem.busy && maddr == 15'h1234)
      chk_bit(mdi[7], 1'b1, "poll bit 7");

  // Hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      err_count++;
      $display("[ERR] %0t timeout", $time);
      close_out();
    end
  end

  initial begin
    {rst, valid, prot, last, addr, wd} = {4'b1000, 15'h0000, 8'h00};
    op = OP_READ;
    {err_count, n_compared, cyc} = '0;
    repeat (12) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    chk_bit(ce_n & we_n & doe_n, 1'b1, "idle pins");
    t_byte();
    t_page();
    t_prot();
    close_out();
  end
endmodule // pep_host_tb
`default_nettype wire
